// >>> src/sppc_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the parallel port clocking block and its test bench
`ifndef SPPC_MAP_SVH
`define SPPC_MAP_SVH

// ==========================================================
// register byte offsets
`define SPPC_CTRL_OFS     12'h000
`define SPPC_STATUS_OFS   12'h004
`define SPPC_IRQ_STS_OFS  12'h008
`define SPPC_IRQ_CLR_OFS  12'h00C
`define SPPC_IRQ_EN_OFS   12'h010

// ==========================================================
// control field positions
`define SPPC_CTRL_TXSEL   0
`define SPPC_CTRL_PABRST  1
`define SPPC_CTRL_TXRATE  2
`define SPPC_CTRL_RXSEL   3
`define SPPC_CTRL_REFHALF 4
`define SPPC_CTRL_RXHALF  5
`define SPPC_CTRL_W       6
`define SPPC_CTRL_RST     6'h02

// ==========================================================
// status and interrupt field positions
`define SPPC_STS_ERR      0
`define SPPC_STS_RUN      1
`define SPPC_STS_FILL     8
`define SPPC_IRQ_TXERR    0
`define SPPC_IRQ_INIT     1
`define SPPC_IRQ_W        2

// ==========================================================
// timing counts in core clock cycles
`define SPPC_RXCLK_HIGH   8'h04

`endif

// >>> src/sppc_pkg.sv
// types shared by the parallel port clocking block
// assumes: compiled before any module that imports it
package sppc_pkg;

	// one character: 8 data bits plus 2 control bits
	typedef logic [9:0] sppc_char_t;

	// phase-align buffer condition
	typedef enum {
		PAB_UNINIT,
		PAB_RUN,
		PAB_FAULT
	} sppc_pab_state_t;

endpackage

// >>> src/sppc_sync.sv
// three-stage synchroniser for inputs from outside the core clock
// assumes: async_in may change at any time relative to clk_in
`timescale 1ns/1ps

module sppc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;

	// ==========================================================
	// stage chain; output follows once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					out_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	assign sync_out = out_reg;

endmodule // sppc_sync

// >>> src/sppc_port_clk.sv
// parallel host port clocking for one transceiver channel
// assumes: APB master on core_clk_in; pins are asynchronous to it
//
// Function
// - reference clock may clock both parallel paths
// - select 0: capture inputs on host clock
// - buffer slip sets error until re-initialised
// - writing buffer reset 0 initialises phase
// - error low means buffer initialised, capturing
// - word sync transmission clears buffer error
// - transmit clock out at one or two times
// - no fixed transmit clock to reference phase
// - half-rate reference: sample on both edges
// - half-rate reference: outputs on both edges
// - receive data timed by selected receive clock
// - full-rate: complementary clocks, data on rise
// - half-rate: data changes on both clock edges
`timescale 1ns/1ps
`include "sppc_map.svh"

module sppc_port_clk #(
	parameter int DEPTH = 4,
	parameter int CW    = 8
) (
	input  wire logic               core_clk_in,
	input  wire logic               rst_b_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [11:0]        paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	input  wire logic               reference_clock_pair_in,
	input  wire logic               host_transmit_input_clock_in,
	input  wire logic [7:0]         transmit_data_in,
	input  wire logic [1:0]         transmit_control_in,
	input  wire logic               word_sync_sent_in,
	output sppc_pkg::sppc_char_t    enc_char_out,
	output logic                    enc_char_valid_out,
	output logic                    transmit_char_clock_out,
	output logic                    transmit_error_flag_out,
	input  wire logic [7:0]         rx_char_in,
	input  wire logic               rx_char_valid_in,
	output logic                    receive_clock_pair_p_out,
	output logic                    receive_clock_pair_n_out,
	output logic      [7:0]         receive_data_out,
	output logic                    irq_out
);
	import sppc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0]   FULL_C = (AW+1)'(DEPTH);
	localparam logic [AW:0]   HALF_C = (AW+1)'(DEPTH/2);
	localparam logic [AW-1:0] HPTR_C = AW'(DEPTH/2);

	// ==========================================================
	// register state
	logic [`SPPC_CTRL_W-1:0] ctrl_reg;
	logic [`SPPC_IRQ_W-1:0]  irq_sts_reg;
	logic [`SPPC_IRQ_W-1:0]  irq_en_reg;
	logic [31:0]             prdata_reg;
	logic                    pready_reg;
	logic                    pslverr_reg;
	logic                    irq_reg;
	logic [31:0]             rdata_w;
	logic                    addr_ok_w;
	logic                    wr_acc;
	logic                    init_pulse;

	// ==========================================================
	// synchronised pins and edges
	logic       ref_lvl;
	logic       host_lvl;
	sppc_char_t tx_in_lvl;
	logic       ref_prev_reg;
	logic       host_prev_reg;
	logic       ref_rise;
	logic       ref_fall;
	logic       ref_tick;
	logic       host_rise;

	// ==========================================================
	// phase-align buffer
	sppc_char_t      pab_mem [DEPTH];
	logic [AW-1:0]   wptr_reg;
	logic [AW-1:0]   rptr_reg;
	logic [AW:0]     count_reg;
	logic [AW:0]     count_next;
	sppc_pab_state_t state_reg;
	sppc_pab_state_t state_next;
	sppc_char_t      enc_char_reg;
	logic            enc_valid_reg;
	logic            err_reg;
	logic            wr_tick;
	logic            overflow;
	logic            underflow;
	logic            wr_ok;
	logic            rd_ok;
	logic            recenter;

	// ==========================================================
	// clock outputs
	logic [CW-1:0] per_cnt_reg;
	logic [CW-1:0] half_len_reg;
	logic          txclk_reg;
	logic          txclk_mid;
	logic          rx_tick;
	logic          rxclk_p_reg;
	logic          rxclk_n_reg;
	logic          rxclk_next;
	logic [7:0]    rx_hi_reg;
	logic [7:0]    rxd_reg;

	// control fields
	wire txsel   = ctrl_reg[`SPPC_CTRL_TXSEL];
	wire txrate  = ctrl_reg[`SPPC_CTRL_TXRATE];
	wire rxsel   = ctrl_reg[`SPPC_CTRL_RXSEL];
	wire refhalf = ctrl_reg[`SPPC_CTRL_REFHALF];
	wire rxhalf  = ctrl_reg[`SPPC_CTRL_RXHALF];

	// ==========================================================
	// pin synchronisers
	sppc_sync #(.W(1)) u_ref_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.async_in (reference_clock_pair_in),
		.sync_out (ref_lvl)
	);
	sppc_sync #(.W(1)) u_host_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.async_in (host_transmit_input_clock_in),
		.sync_out (host_lvl)
	);
	// data path has the same latency as the clock path
	sppc_sync #(.W(10)) u_txd_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.async_in ({transmit_control_in, transmit_data_in}),
		.sync_out (tx_in_lvl)
	);

	// ==========================================================
	// edge detection
	assign ref_rise  = ref_lvl & ~ref_prev_reg;
	assign ref_fall  = ~ref_lvl & ref_prev_reg;
	assign ref_tick  = ref_rise | (refhalf & ref_fall);
	assign host_rise = host_lvl & ~host_prev_reg;

	// ==========================================================
	// APB decode
	assign wr_acc     = psel_in & penable_in & pready_reg & pwrite_in;
	assign init_pulse = wr_acc & (paddr_in == `SPPC_CTRL_OFS)
		& ~pwdata_in[`SPPC_CTRL_PABRST];

	// read mux and address check
	always_comb begin
		rdata_w   = '0;
		addr_ok_w = 1'b1;
		if (paddr_in == `SPPC_CTRL_OFS) begin
			rdata_w[`SPPC_CTRL_W-1:0] = ctrl_reg;
		end else if (paddr_in == `SPPC_STATUS_OFS) begin
			rdata_w[`SPPC_STS_ERR]              = err_reg;
			rdata_w[`SPPC_STS_RUN]              = state_reg == PAB_RUN;
			rdata_w[`SPPC_STS_FILL +: AW+1]     = count_reg;
		end else if (paddr_in == `SPPC_IRQ_STS_OFS) begin
			rdata_w[`SPPC_IRQ_W-1:0] = irq_sts_reg;
		end else if (paddr_in == `SPPC_IRQ_CLR_OFS) begin
			rdata_w = '0;
		end else if (paddr_in == `SPPC_IRQ_EN_OFS) begin
			rdata_w[`SPPC_IRQ_W-1:0] = irq_en_reg;
		end else begin
			addr_ok_w = 1'b0;
		end
	end

	// bus answer, registered; pready in first access cycle
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= psel_in & ~penable_in;
			pslverr_reg <= psel_in & ~penable_in & ~addr_ok_w;
			prdata_reg  <= (psel_in & ~penable_in & ~pwrite_in)
				? rdata_w : 32'h00000000;
		end
	end

	// control and interrupt registers; hardware set beats clear
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ctrl_reg    <= `SPPC_CTRL_RST;
			irq_en_reg  <= '0;
			irq_sts_reg <= '0;
		end else begin
			if (wr_acc && paddr_in == `SPPC_CTRL_OFS) begin
				ctrl_reg <= pwdata_in[`SPPC_CTRL_W-1:0];
			end
			if (wr_acc && paddr_in == `SPPC_IRQ_EN_OFS) begin
				irq_en_reg <= pwdata_in[`SPPC_IRQ_W-1:0];
			end
			irq_sts_reg <= (irq_sts_reg
				& ~((wr_acc && paddr_in == `SPPC_IRQ_CLR_OFS)
				? pwdata_in[`SPPC_IRQ_W-1:0] : '0))
				| {(state_reg != PAB_RUN) && (state_next == PAB_RUN),
				   (state_reg == PAB_RUN) && (state_next == PAB_FAULT)};
		end
	end

	// ==========================================================
	// phase-align buffer control
	// select 1 writes on reference ticks, select 0 on host clock
	assign wr_tick   = txsel ? ref_tick : host_rise;
	// centred fill absorbs the host's bounded drift
	assign overflow  = wr_tick & ~ref_tick & (count_reg == FULL_C);
	assign underflow = ref_tick & ~wr_tick & (count_reg == '0);
	assign wr_ok     = wr_tick & ~overflow;
	assign rd_ok     = ref_tick & ~underflow;
	assign recenter  = init_pulse
		| ((state_reg == PAB_FAULT) & word_sync_sent_in);
	assign count_next = count_reg + {{AW{1'b0}}, wr_ok}
		- {{AW{1'b0}}, rd_ok};

	// buffer condition
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PAB_UNINIT: begin
				if (init_pulse) state_next = PAB_RUN;
			end
			PAB_RUN: begin
				if (init_pulse) state_next = PAB_RUN;
				else if (overflow | underflow) state_next = PAB_FAULT;
			end
			PAB_FAULT: begin
				if (recenter) state_next = PAB_RUN;
			end
			default: state_next = PAB_UNINIT;
		endcase
	end

	// pointers, fill and outgoing character
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			state_reg     <= PAB_UNINIT;
			wptr_reg      <= HPTR_C;
			rptr_reg      <= '0;
			count_reg     <= HALF_C;
			enc_char_reg  <= '0;
			enc_valid_reg <= 1'b0;
			ref_prev_reg  <= 1'b0;
			host_prev_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			ref_prev_reg  <= ref_lvl;
			host_prev_reg <= host_lvl;
			enc_valid_reg <= rd_ok & (state_reg == PAB_RUN) & ~recenter;
			if (rd_ok) enc_char_reg <= pab_mem[rptr_reg];
			if (recenter) begin
				// any host phase offset becomes the centre point
				wptr_reg  <= HPTR_C;
				rptr_reg  <= '0;
				count_reg <= HALF_C;
			end else begin
				if (wr_ok) wptr_reg <= wptr_reg + 1'b1;
				if (rd_ok) rptr_reg <= rptr_reg + 1'b1;
				count_reg <= count_next;
			end
		end
	end

	// buffer storage needs no reset
	always_ff @(posedge core_clk_in) begin
		if (wr_ok) pab_mem[wptr_reg] <= tx_in_lvl;
	end

	// error flag is reference-timed, low only when running
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			err_reg <= 1'b1;
		end else if (ref_tick) begin
			err_reg <= state_next != PAB_RUN;
		end
	end

	// ==========================================================
	// transmit clock out: follows reference edges, doubled on demand
	// phase is only loosely tied to the reference
	assign txclk_mid = txrate & (per_cnt_reg == (half_len_reg >> 1))
		& (half_len_reg > CW'(1));

	// half-period measurement and toggle
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			per_cnt_reg  <= '0;
			half_len_reg <= '0;
			txclk_reg    <= 1'b0;
		end else begin
			if (ref_rise | ref_fall) begin
				per_cnt_reg  <= '0;
				half_len_reg <= per_cnt_reg;
			end else if (per_cnt_reg != '1) begin
				per_cnt_reg <= per_cnt_reg + 1'b1;
			end
			if (ref_rise | ref_fall | txclk_mid) begin
				txclk_reg <= ~txclk_reg;
			end
		end
	end

	// ==========================================================
	// receive interface clock and data
	assign rx_tick    = rxsel ? ref_tick : rx_char_valid_in;
	assign rxclk_next = rxhalf ? (rx_tick ^ rxclk_p_reg)
		: (rx_tick | (rxclk_p_reg & (rx_hi_reg > 8'h01)));

	// data update on every character, clock pair follows
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			rxclk_p_reg <= 1'b0;
			rxclk_n_reg <= 1'b1;
			rx_hi_reg   <= 8'h00;
			rxd_reg     <= 8'h00;
		end else begin
			rxclk_p_reg <= rxclk_next;
			rxclk_n_reg <= ~rxclk_next;
			if (rx_tick) begin
				rxd_reg   <= rx_char_in;
				rx_hi_reg <= `SPPC_RXCLK_HIGH;
			end else if (rx_hi_reg != 8'h00) begin
				rx_hi_reg <= rx_hi_reg - 8'h01;
			end
		end
	end

	// ==========================================================
	// interrupt line
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_sts_reg & irq_en_reg);
		end
	end

	// ==========================================================
	// outputs
	assign prdata_out               = prdata_reg;
	assign pready_out               = pready_reg;
	assign pslverr_out              = pslverr_reg;
	assign enc_char_out             = enc_char_reg;
	assign enc_char_valid_out       = enc_valid_reg;
	assign transmit_char_clock_out  = txclk_reg;
	assign transmit_error_flag_out  = err_reg;
	assign receive_clock_pair_p_out = rxclk_p_reg;
	assign receive_clock_pair_n_out = rxclk_n_reg;
	assign receive_data_out         = rxd_reg;
	assign irq_out                  = irq_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence slip_s;
		(state_reg == PAB_RUN) && !init_pulse && (overflow || underflow);
	endsequence
	sequence rx_full_tick_s;
		!rxhalf && rx_tick;
	endsequence

	slip_fault_a: assert property (slip_s |=> state_reg == PAB_FAULT)
		else $error("buffer slip did not raise fault");
	fault_hold_a: assert property ((state_reg == PAB_FAULT) && !recenter
		|=> state_reg == PAB_FAULT)
		else $error("fault left without re-initialisation");
	init_run_a: assert property (init_pulse |=> state_reg == PAB_RUN)
		else $error("buffer reset write did not initialise");
	flag_low_a: assert property ((state_next == PAB_RUN) && ref_tick
		|=> !transmit_error_flag_out)
		else $error("error flag high while running");
	wsync_clear_a: assert property ((state_reg == PAB_FAULT)
		&& word_sync_sent_in |=> state_reg == PAB_RUN)
		else $error("word sync did not clear buffer error");
	txclk_base_a: assert property (!txrate && !txclk_mid
		&& (ref_rise || ref_fall)
		|=> transmit_char_clock_out != $past(transmit_char_clock_out))
		else $error("transmit clock missed a reference edge");
	host_cap_a: assert property (!txsel && host_rise && !ref_tick
		&& !recenter && (count_reg != FULL_C)
		|=> wptr_reg == AW'($past(wptr_reg) + 1'b1))
		else $error("host clock edge not captured");
	half_cap_a: assert property (txsel && refhalf && ref_fall
		&& !recenter |=> rptr_reg != $past(rptr_reg))
		else $error("falling reference edge not used");
	err_timed_a: assert property (!ref_tick
		|=> $stable(transmit_error_flag_out))
		else $error("error flag moved off a reference edge");
	rxd_timed_a: assert property ($changed(receive_data_out)
		|-> $past(rx_tick))
		else $error("receive data changed without a character");
	rx_full_a: assert property (rx_full_tick_s |=> receive_clock_pair_p_out
		&& !receive_clock_pair_n_out
		&& receive_data_out == $past(rx_char_in))
		else $error("full-rate data not on true clock rise");
	rx_half_a: assert property (rxhalf && rx_tick
		|=> $changed(receive_clock_pair_p_out))
		else $error("half-rate clock did not toggle with data");

endmodule // sppc_port_clk

// >>> sim/sppc_host_model.sv
// host logic model: host transmit clock and character launch
// assumes: reference clock from the bench, 160 ns period
`timescale 1ns/1ps

module sppc_host_model (
	input  wire logic       ref_clk_in,
	input  wire logic       sel_ref_in,
	input  wire logic       hold_in,
	input  wire logic [9:0] char_in,
	output logic            host_clk_out,
	output logic      [7:0] data_out,
	output logic      [1:0] ctl_out
);
	wire launch_clk = sel_ref_in ? ref_clk_in : host_clk_out;

	// ==========================================================
	// host clock
	// same period as reference, fixed offset; stops only on hold
	initial begin
		host_clk_out = 1'b0;
		#37;
		forever begin
			#80;
			host_clk_out = hold_in ? 1'b0 : ~host_clk_out;
		end
	end

	// ==========================================================
	// character launch
	// change on falling edge so capture edge sees stable data
	initial begin
		data_out = 8'h00;
		ctl_out  = 2'h0;
	end
	always @(negedge launch_clk) begin
		{ctl_out, data_out} <= char_in;
	end
endmodule // sppc_host_model

// >>> sim/sppc_port_clk_test.sv
// self-checking bench for the parallel port clocking block
// assumes: design files under src, host model beside this file
`timescale 1ns/1ps
`include "sppc_map.svh"

module sppc_port_clk_test;
	import sppc_pkg::*;
	logic clk, rst_b, psel, pen, pwr, refc, wsync, rxv, hold, selr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic pready, pslverr, e, txclk, txerr, vld, rxp, rxn, irq, hclk;
	logic [7:0] rxc, rxd, td;
	logic [1:0] tc;
	logic [9:0] hchar;
	sppc_char_t ench;
	int fail_count, checks_done, ntog, nval;

	sppc_port_clk DUT (.core_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .reference_clock_pair_in(refc),
		.host_transmit_input_clock_in(hclk), .transmit_data_in(td),
		.transmit_control_in(tc), .word_sync_sent_in(wsync),
		.enc_char_out(ench), .enc_char_valid_out(vld),
		.transmit_char_clock_out(txclk), .transmit_error_flag_out(txerr),
		.rx_char_in(rxc), .rx_char_valid_in(rxv),
		.receive_clock_pair_p_out(rxp), .receive_clock_pair_n_out(rxn),
		.receive_data_out(rxd), .irq_out(irq));
	sppc_host_model HOST (.ref_clk_in(refc), .sel_ref_in(selr),
		.hold_in(hold), .char_in(hchar), .host_clk_out(hclk),
		.data_out(td), .ctl_out(tc));

	// ==========================================================
	// clocks, time-zero values, watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		refc = 1'b0;
		#1.3;
		forever #80 refc = ~refc;
	end
	initial begin
		{rst_b, psel, pen, pwr, wsync, rxv, hold, selr} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		rxc = 8'h00;
		hchar = 10'h000;
		seed = 32'hC6AD56ED;
		fail_count = 0;
		checks_done = 0;
	end
	initial begin
		#400000;
		fail_count++;
		end_sim();
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = prdata;
		e = pslverr;
		if (n >= 50)
			check(32'h1, 32'h0);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wait_err(input logic v);
		int n;
		n = 0;
		while (txerr !== v && n < 600) begin
			@(negedge clk);
			n++;
		end
	endtask
	// toggles of tx clock and valid pulses over 8 reference periods
	task automatic count_run();
		logic last;
		ntog = 0;
		nval = 0;
		@(negedge clk);
		last = txclk;
		repeat (256) begin
			@(negedge clk);
			if (txclk !== last)
				ntog++;
			if (vld === 1'b1)
				nval++;
			last = txclk;
		end
	endtask
	task automatic rx_tick(input logic [7:0] v);
		@(posedge clk);
		rxv <= 1'b1;
		rxc <= v;
		@(posedge clk);
		rxv <= 1'b0;
		rxc <= ~v;
		@(negedge clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] ctl_tab[4];
		logic [7:0] v;
		logic p0;
		ctl_tab = '{32'h01, 32'h05, 32'h11, 32'h15};
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, unmapped access, enable register
		apb(1'b0, `SPPC_CTRL_OFS, 32'h0);
		check(q, 32'h02);
		check(txerr, 1'b1);
		apb(1'b0, 12'h0FC, 32'h0);
		check({e, q}, {1'b1, 32'h0});
		apb(1'b1, `SPPC_IRQ_EN_OFS, 32'h3);
		apb(1'b0, `SPPC_IRQ_EN_OFS, 32'h0);
		check(q, 32'h3);
		$display("test reset done");
		// reference clock capture, init interrupt
		selr <= 1'b1;
		seed = xs(seed);
		hchar <= seed[9:0];
		apb(1'b1, `SPPC_CTRL_OFS, 32'h01);
		wait_err(1'b0);
		check(txerr, 1'b0);
		apb(1'b0, `SPPC_IRQ_STS_OFS, 32'h0);
		check(q[1], 1'b1);
		check(irq, 1'b1);
		apb(1'b1, `SPPC_IRQ_CLR_OFS, 32'h3);
		repeat (2) @(negedge clk);
		check(irq, 1'b0);
		repeat (200) @(negedge clk);
		while (vld !== 1'b1) @(negedge clk);
		check(ench, seed[9:0]);
		$display("test reference capture done");
		// tx clock rate and half-rate sampling
		foreach (ctl_tab[i]) begin
			apb(1'b1, `SPPC_CTRL_OFS, ctl_tab[i]);
			wait_err(1'b0);
			count_run();
			check(ntog >= (ctl_tab[i][2] ? 31 : 15) &&
				ntog <= (ctl_tab[i][2] ? 33 : 17), 1'b1);
			check(nval >= (ctl_tab[i][4] ? 15 : 7) &&
				nval <= (ctl_tab[i][4] ? 17 : 9), 1'b1);
		end
		$display("test rates done");
		// host clock capture, slip, word sync recovery
		selr <= 1'b0;
		seed = xs(seed);
		hchar <= seed[9:0];
		apb(1'b1, `SPPC_CTRL_OFS, 32'h00);
		wait_err(1'b0);
		check(txerr, 1'b0);
		repeat (300) @(negedge clk);
		while (vld !== 1'b1) @(negedge clk);
		check({ench, txerr}, {seed[9:0], 1'b0});
		apb(1'b1, `SPPC_IRQ_CLR_OFS, 32'h3);
		@(posedge clk);
		hold <= 1'b1;
		wait_err(1'b1);
		check(txerr, 1'b1);
		@(posedge clk);
		hold <= 1'b0;
		repeat (300) @(negedge clk);
		check({txerr, irq}, 2'b11);
		apb(1'b0, `SPPC_STATUS_OFS, 32'h0);
		check(q[`SPPC_STS_ERR], 1'b1);
		@(posedge clk);
		wsync <= 1'b1;
		@(posedge clk);
		wsync <= 1'b0;
		wait_err(1'b0);
		check(txerr, 1'b0);
		apb(1'b1, `SPPC_IRQ_CLR_OFS, 32'h3);
		$display("test host slip done");
		// receive data on full-rate and half-rate receive clocks
		for (int k = 0; k < 6; k++) begin
			if (k == 0 || k == 3)
				apb(1'b1, `SPPC_CTRL_OFS, k == 0 ? 32'h00 : 32'h20);
			repeat (12) @(negedge clk);
			p0 = rxp;
			seed = xs(seed);
			v = seed[7:0];
			rx_tick(v);
			@(negedge clk);
			check({rxd, rxn}, {v, ~rxp});
			if (k < 3) begin
				check(rxp, 1'b1);
				repeat (6) @(negedge clk);
				check({rxp, rxn}, 2'b01);
			end else
				check(rxp, {~p0});
		end
		$display("test receive done");
		end_sim();
	end
endmodule // sppc_port_clk_test
